// ---- src/smbus_slave_bus_front_end.sv ----
/*
  Two-wire slave bus front end: pin filtering, START and STOP
  detection, address match, byte receive and transmit with
  acknowledge, clock-low abort and power-up state of the sensing and
  memory parts.
  Assumes an 8 MHz link sampling clock, a 25 MHz system clock, an
  external pull-up on the bus and pull-downs on the select pins.
*/
// Function
// - long clock low aborts, releases data
// - abort timer runs only inside transactions
// - sample on rise, change on fall
// - zero pulls low, one releases line
// - floating select pins read as zero
// - answer only when select bits match
// - data falls, clock high: START
// - data rises, clock high: STOP, done
// - ignore traffic without preceding START
// - reject pulses up to 50 ns
// - after reset: converting, memory standby
// - power-on reset returns parts to reset
// - first reading within 100 ms
// - address: preamble, select, direction bit
// - acknowledge matching address and received bytes
`timescale 1ns/1ps
module smbus_slave_bus_front_end #(
  parameter int unsigned ABORT_CYCLES =
    smbus_front_pkg::ABORT_MIN_CYCLES,
  parameter int unsigned FIRST_READING_CYCLES =
    smbus_front_pkg::FIRST_READING_CYCLES
) (
  // system clock and power-on reset
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  // link sampling clock
  input  wire logic link_clk_in,
  // bus pins
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_out,
  // address select pins
  input  wire logic device_select_in_0,
  input  wire logic device_select_in_1,
  input  wire logic device_select_in_2,
  // user side, link clock domain
  input  wire logic [smbus_front_pkg::BYTE_W-1:0]     tx_byte_in,
  output logic      [smbus_front_pkg::BYTE_W-1:0]     rx_byte_out,
  output logic                                        rx_strobe_out,
  output logic                                        addr_match_out,
  output logic                                        cmd_read_out,
  output logic      [smbus_front_pkg::PREAMBLE_W-1:0] cmd_preamble_out,
  output logic                                        tx_next_out,
  output logic                                        stop_seen_out,
  // power-up state and abort pulse, system clock domain
  output logic      sensor_convert_out,
  output logic      memory_standby_out,
  output logic      first_reading_valid_out,
  output logic      timeout_abort_out
);
  import smbus_front_pkg::*;

  localparam int LOW_W  = $clog2(ABORT_CYCLES + 1);
  localparam int WAIT_W = $clog2(FIRST_READING_CYCLES + 1);

  logic [1:0]       link_rst_pipe;
  logic             link_rst;
  logic             scl_f;
  logic             sda_f;
  logic             scl_prev;
  logic             sda_prev;
  logic [SEL_W-1:0] sel_meta;
  logic [SEL_W-1:0] sel_sync;
  logic             abort_meta;
  logic             abort_sync;
  logic             abort_seen;
  logic             abort_tgl;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_det;
  logic             stop_det;
  logic             abort_pulse;

  // ==========================================================
  // link reset: asserted at once, released on the link clock
  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      link_rst_pipe <= 2'b11;
    end else begin
      link_rst_pipe <= {link_rst_pipe[0], 1'b0};
    end
  end
  assign link_rst = link_rst_pipe[1];

  // ==========================================================
  // pin conditioning
  glitch_filter_sync #(
    .STABLE_SAMPLES (FILTER_STABLE_SAMPLES),
    .IDLE_LEVEL     (BUS_IDLE_LEVEL)
  ) scl_filter (
    .clk_in    (link_clk_in),
    .rst_in    (link_rst),
    .pin_in    (scl_in),
    .level_out (scl_f)
  );

  glitch_filter_sync #(
    .STABLE_SAMPLES (FILTER_STABLE_SAMPLES),
    .IDLE_LEVEL     (BUS_IDLE_LEVEL)
  ) sda_filter (
    .clk_in    (link_clk_in),
    .rst_in    (link_rst),
    .pin_in    (sda_in),
    .level_out (sda_f)
  );

  // select pins, abort toggle and edge history on the link clock
  always_ff @(posedge link_clk_in or posedge link_rst) begin
    if (link_rst) begin
      sel_meta   <= '0;
      sel_sync   <= '0;
      abort_meta <= 1'b0;
      abort_sync <= 1'b0;
      abort_seen <= 1'b0;
      scl_prev   <= BUS_IDLE_LEVEL;
      sda_prev   <= BUS_IDLE_LEVEL;
    end else begin
      // pads pull down, so an open pin lands here as zero
      sel_meta   <= {device_select_in_2, device_select_in_1,
                     device_select_in_0};
      sel_sync   <= sel_meta;
      abort_meta <= abort_tgl;
      abort_sync <= abort_meta;
      abort_seen <= abort_sync;
      scl_prev   <= scl_f;
      sda_prev   <= sda_f;
    end
  end

  // edges are taken on filtered levels only
  assign scl_rise    = scl_f & ~scl_prev;
  assign scl_fall    = ~scl_f & scl_prev;
  assign start_det   = scl_f & scl_prev & sda_prev & ~sda_f;
  assign stop_det    = scl_f & scl_prev & ~sda_prev & sda_f;
  assign abort_pulse = abort_sync ^ abort_seen;

  // address hit: select field equals the pins
  function automatic logic addr_hit(input logic [BYTE_W-1:0] addr,
                                    input logic [SEL_W-1:0]  pins);
    addr_hit = (addr[SEL_LSB +: SEL_W] == pins);
  endfunction

  // ==========================================================
  // bus state machine
  bus_state_t             state;
  bus_state_t             next_state;
  logic [3:0]             bit_cnt;
  logic [3:0]             next_bit_cnt;
  logic [BYTE_W-1:0]      shift;
  logic [BYTE_W-1:0]      next_shift;
  logic                   next_drive_low;
  logic                   in_txn;
  logic                   next_in_txn;
  logic                   low_in_txn;
  logic [BYTE_W-1:0]      next_rx_byte;
  logic                   next_rx_strobe;
  logic                   next_addr_match;
  logic                   next_read;
  logic [PREAMBLE_W-1:0]  next_preamble;
  logic                   next_tx_next;
  logic                   next_stop_seen;

  always_comb begin
    next_state      = state;
    next_bit_cnt    = bit_cnt;
    next_shift      = shift;
    next_drive_low  = sda_oe_out;
    next_in_txn     = in_txn;
    next_rx_byte    = rx_byte_out;
    next_rx_strobe  = 1'b0;
    next_addr_match = 1'b0;
    next_read       = cmd_read_out;
    next_preamble   = cmd_preamble_out;
    next_tx_next    = 1'b0;
    next_stop_seen  = 1'b0;
    if (abort_pulse) begin
      next_state     = ST_IDLE;
      next_drive_low = 1'b0;
      next_in_txn    = 1'b0;
    end else if (start_det) begin
      // also a repeated start from any state
      next_state     = ST_ADDR;
      next_bit_cnt   = 4'h0;
      next_drive_low = 1'b0;
      next_in_txn    = 1'b1;
    end else if (stop_det) begin
      next_state     = ST_IDLE;
      next_drive_low = 1'b0;
      next_in_txn    = 1'b0;
      next_stop_seen = 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          next_state = ST_IDLE;
        end
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            next_shift   = {shift[BYTE_W-2:0], sda_f};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
            if (state == ST_RX) begin
              next_rx_byte   = shift;
              next_rx_strobe = 1'b1;
              next_state     = ST_ACK;
              next_drive_low = 1'b1;
            end else if (addr_hit(shift, sel_sync)) begin
              next_preamble   = shift[PREAMBLE_LSB +: PREAMBLE_W];
              next_read       = shift[RW_BIT];
              next_addr_match = 1'b1;
              next_state      = ST_ACK;
              next_drive_low  = 1'b1;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == ACK_CLOCK) begin
            next_bit_cnt = 4'h0;
            if (cmd_read_out) begin
              next_shift     = tx_byte_in;
              next_drive_low = ~tx_byte_in[BYTE_W-1];
              next_tx_next   = 1'b1;
              next_state     = ST_TX;
            end else begin
              next_drive_low = 1'b0;
              next_state     = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == BITS_PER_BYTE) begin
              next_drive_low = 1'b0;
              next_state     = ST_TX_ACK;
            end else begin
              next_shift     = {shift[BYTE_W-2:0], 1'b0};
              next_drive_low = ~shift[BYTE_W-2];
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            next_shift   = {shift[BYTE_W-2:0], sda_f};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == ACK_CLOCK) begin
            next_bit_cnt = 4'h0;
            if (!shift[0]) begin
              next_shift     = tx_byte_in;
              next_drive_low = ~tx_byte_in[BYTE_W-1];
              next_tx_next   = 1'b1;
              next_state     = ST_TX;
            end else begin
              // no acknowledge: stay off the bus until stop or start
              next_state = ST_IDLE;
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_in or posedge link_rst) begin
    if (link_rst) begin
      state            <= ST_IDLE;
      bit_cnt          <= 4'h0;
      shift            <= '0;
      sda_oe_out       <= 1'b0;
      sda_out          <= 1'b0;
      in_txn           <= 1'b0;
      low_in_txn       <= 1'b0;
      rx_byte_out      <= '0;
      rx_strobe_out    <= 1'b0;
      addr_match_out   <= 1'b0;
      cmd_read_out     <= 1'b0;
      cmd_preamble_out <= '0;
      tx_next_out      <= 1'b0;
      stop_seen_out    <= 1'b0;
    end else begin
      state            <= next_state;
      bit_cnt          <= next_bit_cnt;
      shift            <= next_shift;
      sda_oe_out       <= next_drive_low;
      sda_out          <= 1'b0;
      in_txn           <= next_in_txn;
      low_in_txn       <= next_in_txn & ~scl_f;
      rx_byte_out      <= next_rx_byte;
      rx_strobe_out    <= next_rx_strobe;
      addr_match_out   <= next_addr_match;
      cmd_read_out     <= next_read;
      cmd_preamble_out <= next_preamble;
      tx_next_out      <= next_tx_next;
      stop_seen_out    <= next_stop_seen;
    end
  end

  // ==========================================================
  // system domain: clock-low abort timer and power-up state
  logic              low_meta;
  logic              low_sync;
  logic [LOW_W-1:0]  low_cnt;
  logic [LOW_W-1:0]  next_low_cnt;
  logic              next_abort_tgl;
  logic              next_abort;
  logic [WAIT_W-1:0] wait_cnt;
  logic [WAIT_W-1:0] next_wait_cnt;

  // timer saturates so one long low gives one abort
  always_comb begin
    next_low_cnt   = '0;
    next_abort     = 1'b0;
    next_abort_tgl = abort_tgl;
    next_wait_cnt  = wait_cnt;
    if (low_sync) begin
      next_low_cnt = low_cnt;
      if (low_cnt != LOW_W'(ABORT_CYCLES)) begin
        next_low_cnt = low_cnt + 1'b1;
      end
      if (low_cnt == LOW_W'(ABORT_CYCLES - 1)) begin
        next_abort     = 1'b1;
        next_abort_tgl = ~abort_tgl;
      end
    end
    if (wait_cnt != WAIT_W'(FIRST_READING_CYCLES)) begin
      next_wait_cnt = wait_cnt + 1'b1;
    end
  end

  // power-on reset drops both parts back to reset mode
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      low_meta                <= 1'b0;
      low_sync                <= 1'b0;
      low_cnt                 <= '0;
      abort_tgl               <= 1'b0;
      timeout_abort_out       <= 1'b0;
      wait_cnt                <= '0;
      sensor_convert_out      <= 1'b0;
      memory_standby_out      <= 1'b0;
      first_reading_valid_out <= 1'b0;
    end else begin
      low_meta                <= low_in_txn;
      low_sync                <= low_meta;
      low_cnt                 <= next_low_cnt;
      abort_tgl               <= next_abort_tgl;
      timeout_abort_out       <= next_abort;
      wait_cnt                <= next_wait_cnt;
      sensor_convert_out      <= 1'b1;
      memory_standby_out      <= 1'b1;
      first_reading_valid_out <=
        (next_wait_cnt == WAIT_W'(FIRST_READING_CYCLES));
    end
  end

  // ==========================================================
  // checks
  property p_abort_release;
    @(posedge link_clk_in) disable iff (link_rst)
    abort_pulse |=> (state == ST_IDLE) && !sda_oe_out && !in_txn;
  endproperty
  a_abort_release: assert property (p_abort_release)
    else $error("abort did not release the data line");

  property p_count_in_txn;
    @(posedge sys_clk_in) disable iff (rst_in)
    !low_sync |=> (low_cnt == '0) && !timeout_abort_out;
  endproperty
  a_count_in_txn: assert property (p_count_in_txn)
    else $error("abort timer ran outside a low clock in a transaction");

  property p_drive_on_fall;
    @(posedge link_clk_in) disable iff (link_rst)
    (sda_oe_out != $past(sda_oe_out)) |->
      $past(scl_fall || start_det || stop_det || abort_pulse);
  endproperty
  a_drive_on_fall: assert property (p_drive_on_fall)
    else $error("data drive changed away from a falling clock");

  property p_open_drain;
    @(posedge link_clk_in) disable iff (link_rst)
    sda_oe_out |-> (sda_out == 1'b0);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("data line driven high");

  property p_mismatch;
    @(posedge link_clk_in) disable iff (link_rst)
    (state == ST_ADDR && scl_fall && bit_cnt == BITS_PER_BYTE &&
     !start_det && !stop_det && !abort_pulse &&
     shift[SEL_LSB +: SEL_W] != sel_sync)
    |=> (state == ST_IDLE) && !sda_oe_out && !addr_match_out;
  endproperty
  a_mismatch: assert property (p_mismatch)
    else $error("answered a foreign address");

  property p_start;
    @(posedge link_clk_in) disable iff (link_rst)
    (start_det && !abort_pulse) |=>
      (state == ST_ADDR) && (bit_cnt == 4'h0) && in_txn;
  endproperty
  a_start: assert property (p_start)
    else $error("start not taken");

  property p_stop;
    @(posedge link_clk_in) disable iff (link_rst)
    (stop_det && !start_det && !abort_pulse) |=>
      (state == ST_IDLE) && !sda_oe_out && !in_txn && stop_seen_out;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not end the command");

  property p_idle_hold;
    @(posedge link_clk_in) disable iff (link_rst)
    (state == ST_IDLE && !start_det) |=> (state == ST_IDLE);
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("left idle without a start");

  property p_ack_rx;
    @(posedge link_clk_in) disable iff (link_rst)
    (state == ST_RX && scl_fall && bit_cnt == BITS_PER_BYTE &&
     !start_det && !stop_det && !abort_pulse)
    |=> sda_oe_out && rx_strobe_out && (rx_byte_out == $past(shift));
  endproperty
  a_ack_rx: assert property (p_ack_rx)
    else $error("received byte not acknowledged");

  property p_first_reading;
    @(posedge sys_clk_in) disable iff (rst_in)
    $rose(first_reading_valid_out) |->
      sensor_convert_out && memory_standby_out &&
      (wait_cnt == WAIT_W'(FIRST_READING_CYCLES));
  endproperty
  a_first_reading: assert property (p_first_reading)
    else $error("first reading flag at the wrong time");

  c_addr_match: cover property (@(posedge link_clk_in)
    disable iff (link_rst) addr_match_out);
  c_read_byte: cover property (@(posedge link_clk_in)
    disable iff (link_rst) tx_next_out && cmd_read_out);
  c_write_byte: cover property (@(posedge link_clk_in)
    disable iff (link_rst) rx_strobe_out);
  c_timeout: cover property (@(posedge sys_clk_in)
    disable iff (rst_in) timeout_abort_out);

endmodule

// ---- shared/smbus_front_pkg.sv ----
/*
  Constants and types for the two-wire slave bus front end: clock
  periods, abort and power-up timings, glitch filter depth, address
  field layout and the bus state encoding.
  Assumes a 25 MHz system clock and an 8 MHz link sampling clock.
*/
package smbus_front_pkg;

  // ==========================================================
  // clock periods
  localparam int unsigned SYS_CLK_PERIOD_NS  = 40;
  localparam int unsigned LINK_CLK_PERIOD_NS = 125;

  // ==========================================================
  // clock-low abort window, limits in ms
  localparam int unsigned CLOCK_LOW_ABORT_MIN_MS = 25;
  localparam int unsigned CLOCK_LOW_ABORT_MAX_MS = 35;
  // least time, rounded up to whole cycles
  localparam int unsigned ABORT_MIN_CYCLES =
    (CLOCK_LOW_ABORT_MIN_MS * 1000000 + SYS_CLK_PERIOD_NS - 1)
    / SYS_CLK_PERIOD_NS;

  // ==========================================================
  // first reading delay, longest time, rounded down
  localparam int unsigned FIRST_READING_DELAY_MS = 100;
  localparam int unsigned FIRST_READING_CYCLES =
    (FIRST_READING_DELAY_MS * 1000000) / SYS_CLK_PERIOD_NS;

  // ==========================================================
  // glitch reject width and filter depth on the link clock
  localparam int unsigned GLITCH_REJECT_WIDTH_NS = 50;
  localparam int unsigned GLITCH_SAMPLES =
    (GLITCH_REJECT_WIDTH_NS + LINK_CLK_PERIOD_NS - 1)
    / LINK_CLK_PERIOD_NS;
  localparam int unsigned FILTER_STABLE_SAMPLES = GLITCH_SAMPLES + 1;

  // ==========================================================
  // address byte layout and bit counts
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned PREAMBLE_W  = 4;
  localparam int unsigned SEL_W       = 3;
  localparam int unsigned PREAMBLE_LSB = 4;
  localparam int unsigned SEL_LSB     = 1;
  localparam int unsigned RW_BIT      = 0;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [3:0]  ACK_CLOCK     = 4'h9;

  // ==========================================================
  // reset values
  localparam logic BUS_IDLE_LEVEL = 1'b1;

  // ==========================================================
  // bus state
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_ACK    = 3'b010,
    ST_RX     = 3'b011,
    ST_TX     = 3'b100,
    ST_TX_ACK = 3'b101
  } bus_state_t;

endpackage

// ---- src/glitch_filter_sync.sv ----
/*
  Pin synchroniser and glitch filter: two flip-flops, then a level
  that only follows the pin after it has held for STABLE_SAMPLES
  samples in a row.
  Assumes the pin is asynchronous to clk_in.
*/
`timescale 1ns/1ps
module glitch_filter_sync #(
  parameter int unsigned STABLE_SAMPLES = 2,
  parameter logic        IDLE_LEVEL     = 1'b1
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // pin and filtered level
  input  wire logic pin_in,
  output logic      level_out
);

  localparam int RUN_W = $clog2(STABLE_SAMPLES + 1);

  logic             meta;
  logic             sync;
  logic [RUN_W-1:0] run;
  logic [RUN_W-1:0] next_run;
  logic             next_level;

  // ==========================================================
  // synchroniser, first stage feeds only the second
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta <= IDLE_LEVEL;
      sync <= IDLE_LEVEL;
    end else begin
      meta <= pin_in;
      sync <= meta;
    end
  end

  // ==========================================================
  // stability count; a short pulse resets it before it flips
  always_comb begin
    next_run   = '0;
    next_level = level_out;
    if (sync != level_out) begin
      if (run == RUN_W'(STABLE_SAMPLES - 1)) begin
        next_level = sync;
      end else begin
        next_run = run + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      run       <= '0;
      level_out <= IDLE_LEVEL;
    end else begin
      run       <= next_run;
      level_out <= next_level;
    end
  end

  // ==========================================================
  // checks
  property p_filter_hold;
    @(posedge clk_in) disable iff (rst_in)
    (level_out != $past(level_out)) |->
      ($past(run) == RUN_W'(STABLE_SAMPLES - 1)) &&
      ($past(sync) == level_out);
  endproperty
  a_filter_hold: assert property (p_filter_hold)
    else $error("filtered level moved before the pin was stable");

endmodule

// ---- test/host_master.sv ----
/*
  Host bus master model: makes the clock, START, STOP and 9-bit slots.
  Assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/1ps
module host_master (
  // resolved wire and master drives
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  // quarter bit; 250 kHz keeps lows far above the drive latency
  localparam int Q = 1000;
  initial scl_out = 1'b1;
  initial sda_oe_out = 1'b0;
  // open drain slot: pull for zero, release for one
  task automatic byte9(input logic [8:0] o, output logic [8:0] i);
    for (int k = 8; k >= 0; k--) begin
      scl_out = 1'b0;
      #Q sda_oe_out = !o[k]; // data moves only with clock low
      #Q scl_out = 1'b1;
      #Q i[k] = sda_in;
      #Q scl_out = 1'b0;
    end
  endtask
  // entered only from an idle bus
  task automatic start();
    sda_oe_out = 1'b1;
    #Q scl_out = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_oe_out = 1'b1;
    #Q scl_out = 1'b1;
    #Q sda_oe_out = 1'b0;
    #(4*Q);
  endtask
endmodule

// ---- test/smbus_slave_bus_front_end_test.sv ----
/*
  Self-checking bench for the slave front end with a host model.
  Assumes pull-up on data and pull-downs on the select pins.
*/
`timescale 1ns/1ps
module smbus_slave_bus_front_end_test;
  import smbus_front_pkg::*;
  logic       sys_clk = 1'b0, link_clk = 1'b0, rst = 1'b1;
  logic       glitch = 1'b0, stop_flag = 1'b0;
  logic       h_scl, h_oe, oe, rx_stb, match, rd, stop_seen;
  logic       conv, stby, valid, abort;
  logic       sdo, tx_nxt;
  logic [7:0] note;
  int         n_txnext = 0;
  logic [2:0] sel_drv = 3'bzzz;
  tri0  [2:0] sel_w;
  logic [7:0] txb = 8'h00, rxb, q[$];
  logic [3:0] pre;
  logic [8:0] r;
  int         n_mismatch = 0, cmp_count = 0, n_abort = 0, cyc = 0;
  wire        sda_w = !(h_oe | oe | glitch);
  assign sel_w = sel_drv;
  // clocks, link phase offset on purpose
  initial forever #20 sys_clk = !sys_clk;
  initial begin
    #7;
    forever #62.5 link_clk = !link_clk;
  end
  smbus_slave_bus_front_end #(.ABORT_CYCLES(200),
    .FIRST_READING_CYCLES(100)) i_dut (
    .sys_clk_in(sys_clk), .rst_in(rst), .link_clk_in(link_clk),
    .scl_in(h_scl), .sda_in(sda_w), .sda_out(sdo), .sda_oe_out(oe),
    .device_select_in_0(sel_w[0]), .device_select_in_1(sel_w[1]),
    .device_select_in_2(sel_w[2]), .tx_byte_in(txb),
    .rx_byte_out(rxb), .rx_strobe_out(rx_stb), .addr_match_out(match),
    .cmd_read_out(rd), .cmd_preamble_out(pre), .tx_next_out(tx_nxt),
    .stop_seen_out(stop_seen), .sensor_convert_out(conv),
    .memory_standby_out(stby), .first_reading_valid_out(valid),
    .timeout_abort_out(abort));
  host_master i_host (.sda_in(sda_w), .scl_out(h_scl), .sda_oe_out(h_oe));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // oldest note against each received address or data byte
  always @(posedge link_clk) begin
    if (stop_seen === 1'b1)
      stop_flag = 1'b1;
    if (tx_nxt === 1'b1)
      n_txnext++;
    if (oe === 1'b1)
      check({7'h0, sdo}, 8'h00);
    if (rx_stb === 1'b1 || match === 1'b1) begin
      note = q.size() ? q.pop_front() : 8'hxx;
      check(rx_stb ? rxb : {pre, 3'h0, rd}, note);
    end
  end
  // abort pulses and hang limit
  always @(posedge sys_clk) begin
    cyc++;
    if (abort === 1'b1)
      n_abort++;
    if (cyc == 100000) begin
      n_mismatch++;
      complete_run();
    end
  end
  // one transaction; expected notes queued before the slot runs
  task automatic txn(input logic [3:0] p, input logic [2:0] s,
                     input logic dir, input logic ack, input int nd);
    logic [7:0] d;
    if (ack)
      q.push_back({p, 3'h0, dir});
    i_host.start();
    i_host.byte9({p, s, dir, 1'b1}, r);
    check({7'h0, r[0]}, {7'h0, !ack});
    for (int k = 0; k < nd; k++) begin
      d = 8'($urandom);
      if (!dir)
        q.push_back(d);
      i_host.byte9(dir ? {8'hff, k == nd - 1} : {d, 1'b1}, r);
      check(dir ? r[8:1] : {7'h0, r[0]}, dir ? txb : 8'h00);
    end
    stop_flag = 1'b0;
    i_host.stop();
    if (ack)
      check({7'h0, stop_flag}, 8'h01);
  endtask
  initial begin
    void'($urandom(32'h89ac));
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    check({6'h0, conv, stby}, 8'h03);
    repeat (98) @(negedge sys_clk);
    check({7'h0, valid}, 8'h00);
    repeat (4) @(negedge sys_clk);
    check({7'h0, valid}, 8'h01);
    txn(4'h3, 3'h0, 1'b0, 1'b1, 2);
    @(negedge sys_clk);
    sel_drv = 3'($urandom);
    txb = 8'($urandom);
    txn(4'ha, sel_drv, 1'b1, 1'b1, 2);
    txn(4'h3, sel_w ^ 3'h1, 1'b0, 1'b0, 0);
    // short dip while clock high, then a slot with no START
    #1000 glitch = 1'b1;
    #40 glitch = 1'b0;
    i_host.byte9({4'h3, sel_w, 2'b01}, r);
    check({7'h0, r[0]}, 8'h01);
    repeat (300) @(negedge sys_clk);
    check(8'(n_abort), 8'h00);
    i_host.stop();
    // read leaves the device pulling data, then clock held low
    txb = 8'h00;
    q.push_back({4'ha, 3'h0, 1'b1});
    i_host.start();
    i_host.byte9({4'ha, sel_w, 2'b11}, r);
    repeat (300) @(negedge sys_clk);
    check(8'(n_abort), 8'h01);
    check({7'h0, oe}, 8'h00);
    i_host.stop();
    // second power-on reset in mid-run
    rst = 1'b1;
    repeat (3) @(negedge sys_clk);
    check({6'h0, conv, stby}, 8'h00);
    rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    check({6'h0, conv, stby}, 8'h03);
    check(8'(n_txnext), 8'h03);
    check(8'(q.size()), 8'h00);
    complete_run();
  end
endmodule
